// ### dac_link_assertions.sv
/*
  Checker of the serial front end, bound to its top module.
  Assumes one pclk domain and frames spaced as the host model spaces them.
*/
`timescale 1ns/100ps
module dac_link_checker (
  // Clock and reset
  input wire logic            pclk,
  input wire logic            presetn,
  // APB
  input wire logic [7:0]      paddr,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [31:0]     pwdata,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  // Link
  input wire logic            frame_sel_n,
  input wire logic            sclk,
  input wire logic            din,
  input wire logic            dout,
  // Converter side
  input wire logic [7:0][9:0] out_code,
  input wire logic [7:0]      ref_group_high,
  input wire logic            out_update
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_ref_map_fixed: assert property (ref_group_high == 8'hF0)
    else $error("reference map wrong");
  a_update_after_change: assert property ($changed(out_code) |-> ##[0:1] out_update)
    else $error("no update pulse");
  a_update_one_cycle: assert property (out_update |=> !out_update)
    else $error("update pulse too long");
  a_code_when_idle: assert property ($changed(out_code) |-> frame_sel_n)
    else $error("output changed inside frame");
  a_chain_idle_low: assert property (frame_sel_n [*8] |-> !dout)
    else $error("chain output high while idle");
  a_chain_rise_frame: assert property ($rose(dout) |-> !frame_sel_n)
    else $error("chain output rose outside frame");
  a_ready_no_wait: assert property (psel && penable |-> pready)
    else $error("wait state inserted");
  a_unmapped_error: assert property (psel && penable && paddr == 8'hFC |-> pslverr)
    else $error("unmapped access accepted");

  // Main scenarios reached
  c_update: cover property (out_update);
  c_chain: cover property ($rose(dout));
  c_error: cover property (psel && penable && pslverr);
endmodule

bind dac_link_frontend dac_link_checker u_chk (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_sel_n(frame_sel_n), .sclk(sclk), .din(din), .dout(dout), .out_code(out_code),
  .ref_group_high(ref_group_high), .out_update(out_update));

// ### dac_link_frontend.sv
/*
  Serial write front end of an eight-channel 10-bit converter with an APB
  register window. Link pins are sampled on pclk, which must run well above
  the serial clock (at least 8 pclk per serial period).
*/
// The register offsets and the APB interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module dac_link_frontend (
  // Clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // APB slave
  input  wire logic [7:0]              paddr,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Serial link
  input  wire logic                    frame_sel_n,
  input  wire logic                    sclk,
  input  wire logic                    din,
  output logic                         dout,
  // Converter side
  output logic      [7:0][9:0]         out_code,
  output logic      [7:0]              ref_group_high,
  output logic                         out_update
);

  // ---------------------------------------------------------------
  // Declarations
  // ---------------------------------------------------------------
  // Sampled pins, frame state and mode
  dac_link_pkg::link_pins_s  pins_raw;
  dac_link_pkg::link_pins_s  pins;
  dac_link_pkg::link_pins_s  pins_prev_q;
  dac_link_pkg::link_state_e state_q;
  dac_link_pkg::dac_mode_e   mode_q;

  // Frame, channel and bus registers
  logic [dac_link_pkg::CNT_W-1:0]      cnt_q;
  logic [dac_link_pkg::FRAME_BITS-1:0] shift_q;
  logic [dac_link_pkg::FRAME_BITS-1:0] last_frame_q;
  logic [dac_link_pkg::CODE_W-1:0]     data_q [dac_link_pkg::NUM_CH];
  logic [dac_link_pkg::CODE_W-1:0]     out_q  [dac_link_pkg::NUM_CH];
  logic [1:0]                          ctrl_q;
  logic [7:0]                          exec_cnt_q;
  logic [7:0]                          abort_cnt_q;
  logic                                dout_q;
  logic                                upd_q;
  logic [31:0]                         rdata_q;
  logic                                err_q;

  // Decoded strobes and frame fields
  logic                                sel_fall;
  logic                                sel_rise;
  logic                                clk_fall;
  logic                                shift_en;
  logic                                exec_now;
  logic                                abort_now;
  logic                                sw_update;
  logic                                apb_setup;
  logic                                apb_wr;
  logic [3:0]                          cmd;
  logic [2:0]                          chan_sel;
  logic [dac_link_pkg::CODE_W-1:0]     payload;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  // Channel index of a channel-window address
  function automatic logic [2:0] chan_of(input logic [7:0] a);
    chan_of = a[4:2];
  endfunction

  // Address falls inside an eight-word window at base
  function automatic logic in_window(input logic [7:0] a, input logic [7:0] base);
    in_window = (a[7:5] == base[7:5]) && (a[1:0] == 2'h0);
  endfunction

  // Plain channel write aimed at channel idx
  function automatic logic hits_channel(input logic [3:0] op, input logic [2:0] sel, input logic [2:0] idx);
    hits_channel = !op[3] && (sel == idx);
  endfunction

  // Special command that loads the payload straight into channel idx
  function automatic logic loads_payload(input logic [3:0] op, input logic [2:0] idx);
    loads_payload = (op == dac_link_pkg::CMD_BROADCAST)
                    || ((op == dac_link_pkg::CMD_CHA_UPDATE) && (idx == 3'h0));
  endfunction

  // ---------------------------------------------------------------
  // Pin sampling and edge detection
  // ---------------------------------------------------------------
  // All three pins share one sampler so their latencies match
  assign pins_raw.frame_sel_n = frame_sel_n;
  assign pins_raw.sclk        = sclk;
  assign pins_raw.din         = din;

  pin_sync #(
    .W   (dac_link_pkg::SYNC_W),
    .RST (dac_link_pkg::PINS_RST)
  ) u_sync (
    .clk   (pclk),
    .rst_n (presetn),
    .d     (pins_raw),
    .q     (pins)
  );

  // Previous filtered levels for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_prev_q <= dac_link_pkg::PINS_RST;
    end else begin
      pins_prev_q <= pins;
    end
  end

  // Edges of the filtered levels, trailing the pins by 3 to 4 pclk
  // A level must stand 2 pclk to be accepted, hence the sclk limit
  assign sel_fall  = pins_prev_q.frame_sel_n & ~pins.frame_sel_n;
  assign sel_rise  = ~pins_prev_q.frame_sel_n & pins.frame_sel_n;
  assign clk_fall  = pins_prev_q.sclk & ~pins.sclk;
  // Clock only counts while select is low inside a frame
  assign shift_en  = (state_q == dac_link_pkg::ST_SHIFT) && clk_fall && !pins.frame_sel_n;
  assign exec_now  = (state_q == dac_link_pkg::ST_SHIFT) && sel_rise
                     && (cnt_q == dac_link_pkg::CNT_FULL);
  assign abort_now = (state_q == dac_link_pkg::ST_SHIFT) && sel_rise
                     && (cnt_q != dac_link_pkg::CNT_FULL);

  // ---------------------------------------------------------------
  // Frame state
  // ---------------------------------------------------------------
  // Frame opens on select falling, closes on select rising
  // A frame that opens while the link is disabled is never seen
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= dac_link_pkg::ST_IDLE;
    end else begin
      case (state_q)
        dac_link_pkg::ST_IDLE: begin
          if (sel_fall && ctrl_q[dac_link_pkg::CTRL_EN]) begin
            state_q <= dac_link_pkg::ST_SHIFT;
          end
        end
        dac_link_pkg::ST_SHIFT: begin
          if (pins.frame_sel_n) begin
            state_q <= dac_link_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= dac_link_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // Falling-edge counter; past 31 it wraps to 16 for chained frames
  // A count other than 16 at select rise aborts the frame
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (state_q != dac_link_pkg::ST_SHIFT || pins.frame_sel_n) begin
      cnt_q <= '0;
    end else if (shift_en) begin
      if (cnt_q == dac_link_pkg::CNT_TOP) begin
        cnt_q <= dac_link_pkg::CNT_FULL;
      end else begin
        cnt_q <= cnt_q + 5'h01;
      end
    end
  end

  // Shift register, first bit ends at the top
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_q <= '0;
    end else if (abort_now) begin
      shift_q <= '0;
    end else if (shift_en) begin
      shift_q <= {shift_q[dac_link_pkg::FRAME_BITS-2:0], pins.din};
    end
  end

  // Forward the oldest bit once sixteen have entered
  // Low until the 17th edge and whenever select is high
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout_q <= 1'b0;
    end else if (pins.frame_sel_n) begin
      dout_q <= 1'b0;
    end else if (shift_en) begin
      if (cnt_q >= dac_link_pkg::CNT_FULL) begin
        dout_q <= shift_q[dac_link_pkg::FRAME_BITS-1];
      end else begin
        dout_q <= 1'b0;
      end
    end
  end

  assign dout = dout_q;

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  assign cmd      = shift_q[dac_link_pkg::CMD_MSB:dac_link_pkg::CMD_LSB];
  assign chan_sel = shift_q[dac_link_pkg::SEL_MSB:dac_link_pkg::SEL_LSB];
  assign payload  = shift_q[dac_link_pkg::PAY_MSB:dac_link_pkg::PAY_LSB];

  // Operating mode, register-only after reset
  // Mode frames change no channel register; channel frames use the old mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= dac_link_pkg::MODE_REG_ONLY;
    end else if (exec_now && cmd == dac_link_pkg::CMD_REG_ONLY) begin
      mode_q <= dac_link_pkg::MODE_REG_ONLY;
    end else if (exec_now && cmd == dac_link_pkg::CMD_WRITE_THRU) begin
      mode_q <= dac_link_pkg::MODE_WRITE_THRU;
    end
  end

  // ---------------------------------------------------------------
  // Channel registers and outputs
  // ---------------------------------------------------------------
  for (genvar c = 0; c < dac_link_pkg::NUM_CH; c++) begin : g_ch
    // Data register of one channel
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        data_q[c] <= dac_link_pkg::CODE_RST;
      end else if (exec_now) begin
        if (hits_channel(cmd, chan_sel, 3'(c))) begin
          data_q[c] <= payload;
        end else if (loads_payload(cmd, 3'(c))) begin
          data_q[c] <= payload;
        end
      end
    end

    // Output code of one channel
    // Write-through applies to plain channel writes only
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        out_q[c] <= dac_link_pkg::CODE_RST;
      end else if (exec_now) begin
        if (hits_channel(cmd, chan_sel, 3'(c))) begin
          if (mode_q == dac_link_pkg::MODE_WRITE_THRU) begin
            out_q[c] <= payload;
          end
        end else if (loads_payload(cmd, 3'(c))) begin
          out_q[c] <= payload;
        end else if (cmd == dac_link_pkg::CMD_UPDATE_ALL
                     || cmd == dac_link_pkg::CMD_CHA_UPDATE) begin
          out_q[c] <= data_q[c];
        end
      end else if (sw_update) begin
        out_q[c] <= data_q[c];
      end
    end

    assign out_code[c]       = out_q[c];
    assign ref_group_high[c] = dac_link_pkg::REF_HIGH_MAP[c];
  end

  // One-cycle pulse whenever any output code may change
  // Also pulses on mode frames, which leave the codes untouched
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      upd_q <= 1'b0;
    end else begin
      upd_q <= exec_now || sw_update;
    end
  end

  assign out_update = upd_q;

  // ---------------------------------------------------------------
  // Frame bookkeeping
  // ---------------------------------------------------------------
  // Last executed frame and event counters
  // Both counters wrap silently at 255
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_frame_q <= '0;
      exec_cnt_q   <= '0;
      abort_cnt_q  <= '0;
    end else begin
      if (exec_now) begin
        last_frame_q <= shift_q;
        exec_cnt_q   <= exec_cnt_q + 8'h01;
      end
      if (abort_now) begin
        abort_cnt_q <= abort_cnt_q + 8'h01;
      end
    end
  end

  // ---------------------------------------------------------------
  // APB slave
  // ---------------------------------------------------------------
  // Zero wait states: every access completes in its first cycle
  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pwrite && (paddr == dac_link_pkg::OFS_CTRL);
  // Software update loses to a frame executing in the same cycle
  assign sw_update = apb_wr && pwdata[dac_link_pkg::CTRL_UPD] && !exec_now;

  // Control register; update bit self-clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= dac_link_pkg::CTRL_RST;
    end else if (apb_wr) begin
      ctrl_q <= {1'b0, pwdata[dac_link_pkg::CTRL_EN]};
    end
  end

  // Read data and error prepared in the setup cycle
  // Writes to status or frame words decode like reads, with no effect
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q <= '0;
      err_q   <= 1'b0;
    end else if (apb_setup) begin
      err_q   <= 1'b0;
      rdata_q <= '0;
      if (paddr == dac_link_pkg::OFS_CTRL) begin
        rdata_q <= {30'h00000000, ctrl_q};
      end else if (paddr == dac_link_pkg::OFS_STATUS) begin
        rdata_q <= {8'h00, abort_cnt_q, exec_cnt_q, 5'h00, state_q, mode_q};
      end else if (paddr == dac_link_pkg::OFS_FRAME) begin
        rdata_q <= {16'h0000, last_frame_q};
      end else if (!pwrite && in_window(paddr, dac_link_pkg::OFS_DATA0)) begin
        rdata_q <= {22'h000000, data_q[chan_of(paddr)]};
      end else if (!pwrite && in_window(paddr, dac_link_pkg::OFS_OUT0)) begin
        rdata_q <= {22'h000000, out_q[chan_of(paddr)]};
      end else begin
        err_q <= 1'b1;
      end
    end
  end

  assign prdata  = rdata_q;
  assign pready  = 1'b1;
  assign pslverr = err_q && psel && penable;

endmodule

// ### dac_link_frontend_tb.sv
/*
  Self-checking bench of the serial front end: APB tasks and host frames.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/100ps
module dac_link_frontend_tb;
  logic            pclk, presetn, psel, penable, pwrite, err, mode;
  logic [7:0]      paddr, ref_group_high;
  logic [31:0]     pwdata, prdata, rd, cap;
  logic            pready, pslverr, frame_sel_n, sclk, din, dout, out_update;
  logic [7:0][9:0] out_code;
  logic [9:0]      c;
  int              mismatches, tests_run, ex, ab;

  // Clock
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  dac_link_frontend u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_sel_n(frame_sel_n), .sclk(sclk), .din(din), .dout(dout), .out_code(out_code),
    .ref_group_high(ref_group_high), .out_update(out_update));
  serial_host_model u_host (.pclk(pclk), .frame_sel_n(frame_sel_n), .sclk(sclk), .din(din), .dout(dout),
    .cap(cap));

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  function automatic logic [15:0] mk(input logic [2:0] ch, input logic [9:0] code);
    return {1'b0, ch, code, 2'b00};
  endfunction

  task automatic end_of_test;
    if (mismatches == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; rd and err taken at the ready edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 64) begin
      mismatches++;
      $display("MISMATCH %0t bus timeout", $time);
      end_of_test();
    end
  endtask

  task automatic data_is(input int ch, input logic [9:0] code);
    apb(dac_link_pkg::OFS_DATA0 + 8'(4 * ch), 1'b0, 32'h0);
    chk(rd, {22'h0, code});
  endtask

  task automatic status_is;
    apb(dac_link_pkg::OFS_STATUS, 1'b0, 32'h0);
    chk(rd, {8'h00, ab[7:0], ex[7:0], 7'h00, mode});
  endtask

  // Watchdog
  initial begin
    repeat (100000) @(posedge pclk);
    mismatches++;
    $display("MISMATCH %0t run timeout", $time);
    end_of_test();
  end

  // ------------------------------------------------------------
  // Sequence
  // ------------------------------------------------------------
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    {mismatches, tests_run, ex, ab, mode} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(dac_link_pkg::OFS_CTRL, 1'b0, 32'h0);
    chk(rd, 32'h1);
    status_is();
    // Register-only write leaves the output
    u_host.send(mk(3'd3, 10'h2A5), 16);
    ex++;
    data_is(3, 10'h2A5);
    chk({22'h0, out_code[3]}, 32'h0);
    // Write-through on every channel, code extremes included
    u_host.send(32'h9000, 16);
    ex++;
    mode = 1'b1;
    status_is();
    for (int i = 0; i < 8; i++) begin
      c = (i == 7) ? 10'h3FF : 10'(i * 73);
      u_host.send(mk(3'(i), c), 16);
      ex++;
      chk({22'h0, out_code[i]}, {22'h0, c});
      data_is(i, c);
    end
    chk({24'h0, ref_group_high}, 32'hF0);
    // Early select rise discards the frame
    u_host.send(mk(3'd1, 10'h155) >> 1, 15);
    u_host.send(mk(3'd1, 10'h155) >> 8, 8);
    ab += 2;
    chk({22'h0, out_code[1]}, 32'h49);
    data_is(1, 10'h049);
    status_is();
    // Back to register-only, then software update
    u_host.send(32'h8000, 16);
    u_host.send(mk(3'd0, 10'h1C3), 16);
    ex += 2;
    mode = 1'b0;
    chk({22'h0, out_code[0]}, 32'h0);
    apb(dac_link_pkg::OFS_CTRL, 1'b1, 32'h3);
    apb(dac_link_pkg::OFS_OUT0, 1'b0, 32'h0);
    chk(rd, 32'h1C3);
    // Two frames chained: last sixteen bits execute
    u_host.send({mk(3'd5, 10'h0F0), mk(3'd2, 10'h30C)}, 32);
    ex++;
    chk(cap, {16'h0, mk(3'd5, 10'h0F0) >> 1});
    data_is(2, 10'h30C);
    data_is(5, 10'h16D);
    apb(dac_link_pkg::OFS_FRAME, 1'b0, 32'h0);
    chk(rd, {16'h0, mk(3'd2, 10'h30C)});
    // Unmapped read refused, status write accepted without effect
    apb(8'hFC, 1'b0, 32'h0);
    chk({31'h0, err}, 32'h1);
    apb(dac_link_pkg::OFS_STATUS, 1'b1, 32'hFFFF_FFFF);
    chk({31'h0, err}, 32'h0);
    status_is();
    // Disabled link ignores a frame
    apb(dac_link_pkg::OFS_CTRL, 1'b1, 32'h0);
    u_host.send(mk(3'd2, 10'h001), 16);
    data_is(2, 10'h30C);
    apb(dac_link_pkg::OFS_CTRL, 1'b1, 32'h1);
    end_of_test();
  end
endmodule

// ### dac_link_pkg.sv
/*
  Constants, types and register map of the octal converter serial front end.
  Assumes a single pclk domain for the register side; link pins are
  sampled asynchronous inputs.
*/
package dac_link_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int unsigned NUM_CH     = 8;
  localparam int unsigned CODE_W     = 10;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned CNT_W      = 5;
  localparam int unsigned ADDR_W     = 8;
  localparam int unsigned SYNC_W     = 3;

  // ---------------------------------------------------------------
  // Frame layout and counts
  // ---------------------------------------------------------------
  localparam logic [CNT_W-1:0] CNT_FULL = 5'h10;   // 16th falling edge
  localparam logic [CNT_W-1:0] CNT_TOP  = 5'h1F;   // wraps back to full
  localparam int unsigned      CMD_MSB  = 15;
  localparam int unsigned      CMD_LSB  = 12;
  localparam int unsigned      SEL_MSB  = 14;
  localparam int unsigned      SEL_LSB  = 12;
  localparam int unsigned      PAY_MSB  = 11;
  localparam int unsigned      PAY_LSB  = 2;      // low two bits unused

  // ---------------------------------------------------------------
  // Command codes in bits 15..12
  // ---------------------------------------------------------------
  localparam logic [3:0] CMD_REG_ONLY   = 4'h8;
  localparam logic [3:0] CMD_WRITE_THRU = 4'h9;
  localparam logic [3:0] CMD_UPDATE_ALL = 4'hA;
  localparam logic [3:0] CMD_CHA_UPDATE = 4'hB;
  localparam logic [3:0] CMD_BROADCAST  = 4'hC;

  // Reference group of each channel, bit set means high group
  localparam logic [NUM_CH-1:0] REF_HIGH_MAP = 8'hF0;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_FRAME  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DATA0  = 8'h20;
  localparam logic [ADDR_W-1:0] OFS_OUT0   = 8'h40;
  localparam int unsigned       CTRL_EN    = 0;
  localparam int unsigned       CTRL_UPD   = 1;
  localparam logic [1:0]        CTRL_RST   = 2'h1;

  // Reset values
  localparam logic [CODE_W-1:0] CODE_RST  = 10'h000;
  localparam logic [2:0]        PINS_RST  = 3'h1; // select high, clock, data low

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_SHIFT = 2'b01
  } link_state_e;

  typedef enum logic {
    MODE_REG_ONLY = 1'b0,
    MODE_WRITE_THRU = 1'b1
  } dac_mode_e;

  // Sampled link pins travel together
  typedef struct packed {
    logic din;
    logic sclk;
    logic frame_sel_n;
  } link_pins_s;

endpackage

// ### pin_sync.sv
/*
  Three-stage pin sampler with agreement filter.
  Assumes inputs asynchronous to clk; reset value is a constant parameter.
*/
`timescale 1ns/100ps
module pin_sync #(
  parameter int unsigned W   = 3,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, filtered levels out
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // ---------------------------------------------------------------
  // Per-bit sampler
  // ---------------------------------------------------------------
  for (genvar i = 0; i < W; i++) begin : g_bit
    // Level changes only once stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        s1_q[i] <= RST[i];
        s2_q[i] <= RST[i];
        s3_q[i] <= RST[i];
        q[i]    <= RST[i];
      end else begin
        s1_q[i] <= d[i];
        s2_q[i] <= s1_q[i];
        s3_q[i] <= s2_q[i];
        if (s2_q[i] == s3_q[i]) begin
          q[i] <= s3_q[i];
        end
      end
    end
  end

endmodule

// ### serial_host_model.sv
/*
  Host controller: three-wire serial master timed on pclk.
  Assumes a 4 ns pclk; 8 pclk a bit gives a 32 ns link clock.
*/
`timescale 1ns/100ps
module serial_host_model (
  // Clock
  input  wire logic   pclk,
  // Link pins
  output logic        frame_sel_n,
  output logic        sclk,
  output logic        din,
  input  wire logic   dout,
  // Chain output seen before each falling edge
  output logic [31:0] cap
);
  // Idle levels; clock stands still between frames
  initial begin
    frame_sel_n = 1'b1;
    sclk = 1'b0;
    din = 1'b0;
    cap = '0;
  end

  // One frame of n falling edges, bits[n-1] first
  task automatic send(input logic [31:0] bits, input int n);
    @(posedge pclk);
    frame_sel_n <= 1'b0;
    cap <= '0;
    for (int k = n - 1; k >= 0; k--) begin
      @(posedge pclk);
      din <= bits[k];
      sclk <= 1'b1;
      repeat (3) @(posedge pclk);
      cap <= {cap[30:0], dout};
      @(posedge pclk);
      sclk <= 1'b0;
      repeat (3) @(posedge pclk);
    end
    @(posedge pclk);
    din <= 1'b0;
    repeat (7) @(posedge pclk);
    frame_sel_n <= 1'b1;
    repeat (12) @(posedge pclk);
  endtask
endmodule
